// file: logic/atc_params.svh
// Offsets, field positions, reset values and timing counts for the auxiliary timer
`ifndef ATC_PARAMS_SVH
`define ATC_PARAMS_SVH
`define ATC_ADDR_CTRL 16'hff46
`define ATC_ADDR_COUNT 16'hff48
`define ATC_ADDR_CAPTURE 16'hff4a
`define ATC_ADDR_CORE 16'hff4c
`define ATC_CTRL_RESET 16'h0000
`define ATC_COUNT_RESET 16'h0000
`define ATC_BIT_CAPEN 15
`define ATC_BIT_CLRCAP 14
`define ATC_TRIG_HI 13
`define ATC_TRIG_LO 12
`define ATC_BIT_CORR 11
`define ATC_BIT_CAPSRC 10
`define ATC_BIT_REMOTE 9
`define ATC_BIT_EXTDIR 8
`define ATC_BIT_DIR 7
`define ATC_BIT_RUN 6
`define ATC_MODE_HI 5
`define ATC_MODE_LO 3
`define ATC_PAR_HI 2
`define ATC_PAR_LO 0
`define ATC_CORE_RUN_BIT 0
`define ATC_PRESCALE_BASE 8
`endif

// file: logic/atc_pkg.sv
// Types shared by the auxiliary timer control files
package atc_pkg;
   typedef enum logic [2:0] {
      ATC_TIMER = 3'h0,
      ATC_COUNTER = 3'h1,
      ATC_GATED_LOW = 3'h2,
      ATC_GATED_HIGH = 3'h3
   } atc_mode_e;
   typedef logic [15:0] atc_word_t;
endpackage

// file: logic/atc_edge_detect.sv
// Two-flop synchroniser with edge detection for one pin
module atc_edge_detect (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Pin and synchronised outputs
   input wire logic pinAsync,
   output logic level,
   output logic rise,
   output logic fall
);
   logic meta_ff;
   logic sync_ff;
   logic last_ff;

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         meta_ff <= 1'b0;
         sync_ff <= 1'b0;
         last_ff <= 1'b0;
      end else begin
         meta_ff <= pinAsync;
         sync_ff <= meta_ff;
         last_ff <= sync_ff;
      end
   end

   assign level = sync_ff;
   assign rise = sync_ff & ~last_ff;
   assign fall = ~sync_ff & last_ff;
endmodule

// file: logic/atc_aux_timer_control.sv
// Auxiliary timer with control register, capture register and Wishbone slave
//
// Added by the designer: the Wishbone interface to the registers.
`include "atc_params.svh"
module atc_aux_timer_control (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [15:0] wb_adr_i,
   input wire logic [1:0] wb_sel_i,
   input wire logic [15:0] wb_dat_i,
   output logic [15:0] wb_dat_o,
   output logic wb_ack_o,
   output logic wb_err_o,
   // Pins
   input wire logic countInputPin,
   input wire logic externalDirectionPin,
   input wire logic captureInputPin,
   input wire logic otherTimerCountInput,
   input wire logic otherTimerDirectionInput,
   // Core timer side, same clock
   input wire logic coreToggleLatch,
   input wire logic coreToggleBySoftware,
   // Status
   output logic coreRunBit,
   output logic captureEvent
);
   logic [15:0] ctrl_ff;
   logic [15:0] count_ff;
   logic [15:0] capture_ff;
   logic coreRun_ff;
   logic ack_ff;
   logic [15:0] rdata_ff;
   logic [15:0] prescale_ff;
   logic toggleLast_ff;
   logic capEvent_ff;

   logic [15:0] nxt_ctrl;
   logic [15:0] nxt_count;
   logic [15:0] nxt_capture;

   // Synchronised pins
   logic countLvl, countRise, countFall;
   logic dirLvl;
   logic capRise, capFall;
   logic otcRise, otcFall, otdRise, otdFall;

   // Every pin passes the same synchroniser, so edges of different pins stay aligned
   atc_edge_detect i_atc_edge_detect_count (
      .clk(clk),
      .rst_b(rst_b),
      .pinAsync(countInputPin),
      .level(countLvl),
      .rise(countRise),
      .fall(countFall)
   );

   atc_edge_detect i_atc_edge_detect_dir (
      .clk(clk),
      .rst_b(rst_b),
      .pinAsync(externalDirectionPin),
      .level(dirLvl),
      .rise(),
      .fall()
   );

   atc_edge_detect i_atc_edge_detect_cap (
      .clk(clk),
      .rst_b(rst_b),
      .pinAsync(captureInputPin),
      .level(),
      .rise(capRise),
      .fall(capFall)
   );

   atc_edge_detect i_atc_edge_detect_otc (
      .clk(clk),
      .rst_b(rst_b),
      .pinAsync(otherTimerCountInput),
      .level(),
      .rise(otcRise),
      .fall(otcFall)
   );

   atc_edge_detect i_atc_edge_detect_otd (
      .clk(clk),
      .rst_b(rst_b),
      .pinAsync(otherTimerDirectionInput),
      .level(),
      .rise(otdRise),
      .fall(otdFall)
   );

   // Edge selection shared by count input, toggle latch and capture pin
   function automatic logic edgeSel(
      input logic [1:0] sel,
      input logic r,
      input logic f
   );
      unique case (sel)
         2'h0: edgeSel = 1'b0;
         2'h1: edgeSel = r;
         2'h2: edgeSel = f;
         2'h3: edgeSel = r | f;
      endcase
   endfunction

   // Wrap-around count arithmetic, shared by stepping and capture correction
   function automatic logic [15:0] stepUp(input logic [15:0] v);
      stepUp = v + 16'h1;
   endfunction

   function automatic logic [15:0] stepDown(input logic [15:0] v);
      stepDown = v - 16'h1;
   endfunction

   function automatic logic addrHit(input logic [15:0] adr, input logic [15:0] target);
      addrHit = (adr == target);
   endfunction

   // Control fields
   // Plain renames of register bits; reserved mode codes are filtered below
   wire [2:0] modeField = ctrl_ff[`ATC_MODE_HI:`ATC_MODE_LO];
   wire [2:0] inputParameterField = ctrl_ff[`ATC_PAR_HI:`ATC_PAR_LO];
   wire [1:0] captureTriggerSelect = ctrl_ff[`ATC_TRIG_HI:`ATC_TRIG_LO];
   wire captureEnableBit = ctrl_ff[`ATC_BIT_CAPEN];
   wire auxClearOnCapture = ctrl_ff[`ATC_BIT_CLRCAP];
   wire captureCorrectionBit = ctrl_ff[`ATC_BIT_CORR];
   wire captureSourceSelect = ctrl_ff[`ATC_BIT_CAPSRC];
   wire remoteRunSelect = ctrl_ff[`ATC_BIT_REMOTE];
   wire externalDirectionEnable = ctrl_ff[`ATC_BIT_EXTDIR];
   wire directionBit = ctrl_ff[`ATC_BIT_DIR];
   wire auxRunBit = ctrl_ff[`ATC_BIT_RUN];

   // Reserved modes with the top bit set never count
   wire modeLegal = ~modeField[2];
   wire isTimer = modeLegal && (modeField == atc_pkg::ATC_TIMER);
   wire isCounter = modeLegal && (modeField == atc_pkg::ATC_COUNTER);
   wire isGated = modeLegal && modeField[1];
   // Gate is the synchronised count pin; mode bit 0 gives its active level
   wire gateActive = modeField[0] ? countLvl : ~countLvl;

   // Run bit choice; core run is a register here so both timers see one edge
   wire runSel = remoteRunSelect ? coreRun_ff : auxRunBit;
   wire running = runSel && (!isGated || gateActive);

   // Prescaler: tick every BASE << param module clocks
   wire [15:0] prescaleLimit = 16'(`ATC_PRESCALE_BASE) << inputParameterField;
   wire prescaleTick = (prescale_ff >= prescaleLimit - 16'h1);

   // Core toggle latch edges, ignoring software writes
   wire tglRise = coreToggleLatch & ~toggleLast_ff & ~coreToggleBySoftware;
   wire tglFall = ~coreToggleLatch & toggleLast_ff & ~coreToggleBySoftware;
   wire pinEdge = edgeSel(inputParameterField[1:0], countRise, countFall);
   wire tglEdge = edgeSel(inputParameterField[1:0], tglRise, tglFall);
   // Param top bit picks core toggle latch edges instead of the count pin
   wire counterEvent = inputParameterField[2] ? tglEdge : pinEdge;

   wire counterGo = isCounter && counterEvent;
   wire timerGo = (isTimer || isGated) && prescaleTick;
   wire countEvent = running && (counterGo || timerGo);

   // Direction: bit alone or bit xor pin
   wire countDown = directionBit ^ (externalDirectionEnable & dirLvl);

   // Capture trigger
   wire capPinEdge = edgeSel(captureTriggerSelect, capRise, capFall);
   wire otcAny = otcRise | otcFall;
   wire otdAny = otdRise | otdFall;
   wire otherEdge = (captureTriggerSelect[0] & otcAny)
      | (captureTriggerSelect[1] & otdAny);
   wire trigger = captureSourceSelect ? otherEdge : capPinEdge;
   wire doCapture = trigger && captureEnableBit;
   // Clear needs only the trigger, so the pin can reset the timer with capture off
   wire doClear = trigger && auxClearOnCapture;
   wire [15:0] capValue = captureCorrectionBit ? stepDown(count_ff) : count_ff;

   // Bus decode
   // A held request is not taken again while its answer stands
   wire req = wb_cyc_i && wb_stb_i && !ack_ff;
   wire selCtrl = addrHit(wb_adr_i, `ATC_ADDR_CTRL);
   wire selCount = addrHit(wb_adr_i, `ATC_ADDR_COUNT);
   wire selCap = addrHit(wb_adr_i, `ATC_ADDR_CAPTURE);
   wire selCore = addrHit(wb_adr_i, `ATC_ADDR_CORE);
   wire mapped = selCtrl | selCount | selCap | selCore;
   wire wr = req && wb_we_i && mapped;
   // Byte lanes let software update one half of a register alone
   wire [15:0] laneMask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

   // Byte-lane merge shared by the control, count and capture registers
   function automatic logic [15:0] merge(
      input logic [15:0] old,
      input logic [15:0] nw,
      input logic [15:0] m
   );
      merge = (old & ~m) | (nw & m);
   endfunction

   wire [15:0] countStep = countDown ? stepDown(count_ff) : stepUp(count_ff);

   always_comb begin
      nxt_ctrl = ctrl_ff;
      if (wr && selCtrl) begin
         nxt_ctrl = merge(ctrl_ff, wb_dat_i, laneMask);
      end
   end

   // Priority: software write, then clear, then count step
   always_comb begin
      nxt_count = count_ff;
      if (doClear) begin
         nxt_count = 16'h0000;
      end else if (countEvent) begin
         nxt_count = countStep;
      end
      if (wr && selCount) begin
         nxt_count = merge(count_ff, wb_dat_i, laneMask);
      end
   end

   // Capture latches the pre-clear value in the same edge; clear acts on the count
   // afterwards, so the latched word is never zero because of the clear
   always_comb begin
      nxt_capture = capture_ff;
      if (doCapture) begin
         nxt_capture = capValue;
      end else if (wr && selCap) begin
         nxt_capture = merge(capture_ff, wb_dat_i, laneMask);
      end
   end

   // Read data is registered, so it stands unchanged while ack is high
   wire [15:0] readMux = selCtrl ? ctrl_ff
      : selCount ? count_ff
      : selCap ? capture_ff
      : selCore ? {15'h0000, coreRun_ff}
      : 16'h0000;

   // Prescaler restarts while stopped, so a restart always gives a full first period
   wire nxt_coreRun = (wr && selCore && wb_sel_i[0])
      ? wb_dat_i[`ATC_CORE_RUN_BIT] : coreRun_ff;
   wire [15:0] nxt_prescale = (!running || prescaleTick) ? 16'h0000 : prescale_ff + 16'h1;

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         ctrl_ff <= `ATC_CTRL_RESET;
         count_ff <= `ATC_COUNT_RESET;
         capture_ff <= 16'h0000;
      end else begin
         ctrl_ff <= nxt_ctrl;
         count_ff <= nxt_count;
         capture_ff <= nxt_capture;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         coreRun_ff <= 1'b0;
      end else begin
         coreRun_ff <= nxt_coreRun;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         prescale_ff <= 16'h0000;
      end else begin
         prescale_ff <= nxt_prescale;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         toggleLast_ff <= 1'b0;
      end else begin
         toggleLast_ff <= coreToggleLatch;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         capEvent_ff <= 1'b0;
      end else begin
         capEvent_ff <= doCapture;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         ack_ff <= 1'b0;
      end else begin
         ack_ff <= req;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         rdata_ff <= 16'h0000;
      end else begin
         rdata_ff <= readMux;
      end
   end

   // Unmapped addresses answer with err instead of ack
   logic err_ff;
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         err_ff <= 1'b0;
      end else begin
         err_ff <= req && !mapped;
      end
   end

   assign wb_ack_o = ack_ff && !err_ff;
   assign wb_err_o = err_ff;
   assign wb_dat_o = rdata_ff;
   // No overflow pin exists for this timer
   assign coreRunBit = coreRun_ff;
   assign captureEvent = capEvent_ff;
endmodule

// file: testbench/atc_aux_timer_control_props.sv
// Bus and core run checks on the auxiliary timer ports
`include "atc_params.svh"
module atc_aux_timer_control_props (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [15:0] wb_adr_i,
   input wire logic [1:0] wb_sel_i,
   input wire logic [15:0] wb_dat_i,
   input wire logic [15:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic wb_err_o,
   // Status
   input wire logic coreRunBit,
   input wire logic captureEvent
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   logic req, mapd, coreWr;
   assign req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
   assign mapd = wb_adr_i == `ATC_ADDR_CTRL || wb_adr_i == `ATC_ADDR_COUNT
      || wb_adr_i == `ATC_ADDR_CAPTURE || wb_adr_i == `ATC_ADDR_CORE;
   assign coreWr = req && wb_we_i && wb_adr_i == `ATC_ADDR_CORE;
   AST_ACK_LAT: assert property (req && mapd |=> wb_ack_o && !wb_err_o)
      else $error("ack missing one cycle after mapped request");
   AST_ERR_LAT: assert property (req && !mapd |=> wb_err_o && !wb_ack_o)
      else $error("err missing after unmapped request");
   AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   AST_ERR_ZERO: assert property (wb_err_o |-> wb_dat_o == 16'h0000)
      else $error("unmapped read not zero");
   AST_NO_SPUR: assert property ((wb_ack_o || wb_err_o) |-> $past(req))
      else $error("answer without request");
   AST_CORE_WR: assert property (coreWr && wb_sel_i[0] |=> coreRunBit == $past(wb_dat_i[0]))
      else $error("core run bit not written");
   AST_CORE_HOLD: assert property (!$stable(coreRunBit) |-> $past(coreWr))
      else $error("core run bit changed without write");
   AST_RST: assert property ($rose(rst_b) |-> !coreRunBit && !wb_ack_o && !wb_err_o)
      else $error("state not clear after reset");
   cover property (wb_ack_o && !wb_we_i);
   cover property (wb_err_o);
   cover property (captureEvent);
endmodule
bind atc_aux_timer_control atc_aux_timer_control_props i_atc_aux_timer_control_props (.clk,
   .rst_b, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
   .wb_ack_o, .wb_err_o, .coreRunBit, .captureEvent);

// file: testbench/tb_top.sv
// Directed testbench for the auxiliary timer control block
`include "atc_params.svh"
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 0, rst_b = 0, cyc = 0, stb = 0, we = 0;
   logic [15:0] adr = 0, dat = 0, q;
   logic [1:0] sel = 0;
   logic [4:0] pins = 0;
   logic tgl = 0, tglSw = 0;
   int capCount = 0;
   wire logic [15:0] datO;
   wire logic ack, err, coreRun, capEv;
   int mismatches = 0, comparisons = 0;
   always #10 clk = ~clk;
   always @(posedge clk) begin
      if (capEv === 1'b1) begin
         capCount <= capCount + 1;
      end
   end
   atc_aux_timer_control i_atc_aux_timer_control (.clk(clk), .rst_b(rst_b), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
      .wb_dat_o(datO), .wb_ack_o(ack), .wb_err_o(err), .countInputPin(pins[0]),
      .externalDirectionPin(pins[1]), .captureInputPin(pins[2]),
      .otherTimerCountInput(pins[3]), .otherTimerDirectionInput(pins[4]),
      .coreToggleLatch(tgl), .coreToggleBySoftware(tglSw), .coreRunBit(coreRun),
      .captureEvent(capEv));
   task finish_test();
      if (mismatches == 0 && comparisons > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task chk(input string n, input logic [15:0] e, input logic [15:0] g);
      comparisons++;
      if (g !== e) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask
   // Ack is sampled before the edge's own updates land, so read data is taken cleanly
   task bus(input logic w, input logic [15:0] a, input logic [15:0] d);
      int n;
      n = 0;
      @(posedge clk);
      {cyc, stb, we, adr, dat, sel} <= {2'b11, w, a, d, 2'h3};
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && err !== 1'b1 && n < 20);
      if (ack !== 1'b1 && err !== 1'b1) begin
         mismatches++;
         finish_test();
      end else begin
         q = datO;
         {cyc, stb} <= 2'b00;
      end
   endtask
   task rd(input string n, input logic [15:0] a, input logic [15:0] e);
      bus(0, a, 0);
      chk(n, e, q);
   endtask
   task pin(input int i, input logic v);
      @(posedge clk);
      pins[i] <= v;
      repeat (5) @(posedge clk);
   endtask
   task setup(input logic [15:0] c, input logic [15:0] cnt);
      bus(1, `ATC_ADDR_CTRL, 16'h0000);
      bus(1, `ATC_ADDR_COUNT, cnt);
      bus(1, `ATC_ADDR_CTRL, c);
   endtask
   task t_reset();
      rd("ctrl", `ATC_ADDR_CTRL, 16'h0000);
      rd("count", `ATC_ADDR_COUNT, 16'h0000);
      rd("unmapped", 16'hff50, 16'h0000);
      chk("err", 16'h0001, {15'h0, err});
      bus(1, `ATC_ADDR_CTRL, 16'hffff);
      rd("ctrl rw", `ATC_ADDR_CTRL, 16'hffff);
   endtask
   task t_run();
      logic [15:0] a;
      setup(16'h0040, 16'h0000);
      repeat (40) @(posedge clk);
      bus(1, `ATC_ADDR_CTRL, 16'h0000);
      bus(0, `ATC_ADDR_COUNT, 0);
      a = q;
      chk("ticks", 16'h0001, {15'h0, a >= 4 && a <= 7});
      repeat (30) @(posedge clk);
      rd("stopped", `ATC_ADDR_COUNT, a);
      setup(16'h0240, 16'h0000);
      repeat (30) @(posedge clk);
      rd("own run ignored", `ATC_ADDR_COUNT, 16'h0000);
      bus(1, `ATC_ADDR_CORE, 16'h0001);
      chk("core run", 16'h0001, {15'h0, coreRun});
      repeat (30) @(posedge clk);
      bus(1, `ATC_ADDR_CORE, 16'h0000);
      chk("core stop", 16'h0000, {15'h0, coreRun});
      bus(0, `ATC_ADDR_COUNT, 0);
      chk("remote ran", 16'h0001, {15'h0, q != 0});
      setup(16'h00c0, 16'h0100);
      repeat (20) @(posedge clk);
      bus(0, `ATC_ADDR_COUNT, 0);
      chk("down", 16'h0001, {15'h0, q < 16'h0100});
   endtask
   task t_count();
      setup(16'h0058, 16'h0000);
      repeat (40) @(posedge clk);
      rd("gate shut", `ATC_ADDR_COUNT, 16'h0000);
      pin(0, 1);
      repeat (40) @(posedge clk);
      bus(0, `ATC_ADDR_COUNT, 0);
      chk("gate open", 16'h0001, {15'h0, q != 0});
      pin(0, 0);
      setup(16'h0049, 16'h0000);
      repeat (3) begin pin(0, 1); pin(0, 0); end
      rd("rise edges", `ATC_ADDR_COUNT, 16'h0003);
      setup(16'h004b, 16'h0000);
      repeat (2) begin pin(0, 1); pin(0, 0); end
      rd("any edges", `ATC_ADDR_COUNT, 16'h0004);
      pin(1, 1);
      setup(16'h0149, 16'h0010);
      repeat (2) begin pin(0, 1); pin(0, 0); end
      rd("pin down", `ATC_ADDR_COUNT, 16'h000e);
      setup(16'h01c9, 16'h0010);
      pin(0, 1);
      rd("pin inverted", `ATC_ADDR_COUNT, 16'h0011);
      setup(16'h0060, 16'h0007);
      repeat (40) @(posedge clk);
      rd("reserved", `ATC_ADDR_COUNT, 16'h0007);
   endtask
   task t_chain();
      setup(16'h004f, 16'h0000);
      tgl <= 1'b1;
      repeat (3) @(posedge clk);
      {tgl, tglSw} <= 2'b01;
      @(posedge clk);
      {tgl, tglSw} <= 2'b10;
      repeat (3) @(posedge clk);
      rd("chained", `ATC_ADDR_COUNT, 16'h0002);
   endtask
   task t_cap();
      setup(16'hd800, 16'h0050);
      pin(2, 1);
      pin(2, 0);
      rd("corrected", `ATC_ADDR_CAPTURE, 16'h004f);
      rd("cleared", `ATC_ADDR_COUNT, 16'h0000);
      setup(16'h5000, 16'h0033);
      pin(2, 1);
      rd("no capture", `ATC_ADDR_CAPTURE, 16'h004f);
      rd("clear only", `ATC_ADDR_COUNT, 16'h0000);
      setup(16'h9400, 16'h0021);
      pin(3, 1);
      rd("other src", `ATC_ADDR_CAPTURE, 16'h0021);
      rd("kept", `ATC_ADDR_COUNT, 16'h0021);
      setup(16'h8000, 16'h0011);
      pin(2, 0);
      rd("trig off", `ATC_ADDR_CAPTURE, 16'h0021);
      chk("capture events", 16'h0002, capCount[15:0]);
   endtask
   initial begin
      repeat (3) @(posedge clk);
      rst_b <= 1;
      t_reset();
      t_run();
      t_count();
      t_chain();
      t_cap();
      finish_test();
   end
endmodule
